/* hdl/cmd_access_regs.svh */
// Register offsets, field positions, reset values and timing for command and access control
`ifndef CMD_ACCESS_REGS_SVH
`define CMD_ACCESS_REGS_SVH

// Register offsets on the host register port
`define CMD_CONTROL_ADDR        7'h00
`define ACCESS_CONTROL_ADDR     7'h01

// Command register fields
`define STANDBY_BIT             7
`define MODEM_OFF_BIT           6
`define CMD_MSB                 4
`define CMD_LSB                 0
`define CMD_IDLE                5'h00

// Access-control register fields
`define UNLOCK_BIT              7
`define HOST_GRANT_BIT          6
`define MODULE_GRANT_BIT        5
`define PORT_SEL_MSB            3
`define PORT_SEL_LSB            2

// Reset values
`define CMD_CONTROL_RESET       8'h00
`define ACCESS_CONTROL_RESET    8'h40
`define READ_ZERO               8'h00

// Nominal command execution time when no engine reports completion first
`define EXEC_TIME_NS            800
`define CLK_PERIOD_NS           8
`define EXEC_CYCLES             ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hdl/cmd_access_pkg.sv */
// Types shared by the command and access control block
package cmd_access_pkg;

   // Secure-module port selection, as held in the access-control register
   typedef enum logic [1:0] {
      PORT_OFF                = 2'h0,
      PORT_SPI                = 2'h1,
      PORT_LOW_SPEED_TWO_WIRE = 2'h2,
      PORT_TWO_WIRE           = 2'h3
   } module_port_select_type;

   // Command sequencer states, Gray coded along idle, run, done
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_RUN  = 2'h1,
      SEQ_DONE = 2'h3
   } seq_state_type;

endpackage

/* hdl/grant_guard.sv */
// Decides the next values of the two bus grant bits for one access-control write
module grant_guard (
   input  wire logic unlocked_i,
   input  wire logic host_grant_i,
   input  wire logic module_grant_i,
   input  wire logic req_host_i,
   input  wire logic req_module_i,
   output wire logic next_host_o,
   output wire logic next_module_o,
   output wire logic refused_o
);
   import cmd_access_pkg::*;

   wire logic any_set;
   wire logic both_req;

   // A write that only clears grants is allowed; any new set needs the unlock
   assign any_set  = (req_host_i & ~host_grant_i) | (req_module_i & ~module_grant_i);
   assign both_req = req_host_i & req_module_i;

   // A refused write keeps both grants, so the bus never changes half way
   assign refused_o     = both_req | (any_set & ~unlocked_i);
   assign next_host_o   = refused_o ? host_grant_i : req_host_i;
   assign next_module_o = refused_o ? module_grant_i : req_module_i;
endmodule

/* hdl/cmd_sequencer.sv */
// Tracks one running command and reports its end so the command field returns to idle
`include "cmd_access_regs.svh"
module cmd_sequencer #(
   parameter int EXEC_CYCLES = `EXEC_CYCLES
) (
   input  wire logic ref_clk_i,
   input  wire logic rstn_i,
   input  wire logic start_i,
   input  wire logic stop_i,
   input  wire logic engine_done_i,
   output logic      busy_o,
   output logic      finish_o
);
   import cmd_access_pkg::*;

   localparam int CNT_W = $clog2(EXEC_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(EXEC_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   // Refuse a run length the counter cannot serve
   generate
      if (EXEC_CYCLES < 1) begin : g_bad_exec
         $error("EXEC_CYCLES must be at least one");
      end
   endgenerate

   seq_state_type    state;
   seq_state_type    next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   // Next state: a stop or an engine report ends the run early
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         SEQ_IDLE: begin
            if (start_i) begin
               next_state = SEQ_RUN;
               next_count = CNT_LOAD;
            end
         end
         SEQ_RUN: begin
            // A new command written mid-run restarts the run, so its code is not wiped
            if (start_i) begin
               next_count = CNT_LOAD;
            end else if (stop_i || engine_done_i || count == CNT_ONE) begin
               next_state = SEQ_DONE;
            end else begin
               next_count = count - CNT_ONE;
            end
         end
         SEQ_DONE: begin
            next_state = start_i ? SEQ_RUN : SEQ_IDLE;
            next_count = CNT_LOAD;
         end
         default: begin
            next_state = SEQ_IDLE;
         end
      endcase
   end

   // State and outputs held in flip-flops
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state    <= SEQ_IDLE;
         count    <= '0;
         busy_o   <= 1'b0;
         finish_o <= 1'b0;
      end else begin
         state    <= next_state;
         count    <= next_count;
         busy_o   <= (next_state == SEQ_RUN);
         finish_o <= (next_state == SEQ_DONE);
      end
   end
endmodule

/* hdl/command_and_bus_access_ctrl.sv */
// Command register and interface access-control register with their side effects
`include "cmd_access_regs.svh"

// Summary of operation
// - Writing one to command bit 7 puts the device into power-down standby.
// - Command bit 6 at one powers down receiver and transmitter circuits.
// - Command bits 4 to 0 hold the code of the command to execute.
// - Command field returns to idle by itself when the running command ends.
// - Unlock bit 7 at one lets the next write set a grant bit in the access-control register.
// - The first write after unlocking clears the unlock bit; one write only.
// - Host grant bit 6 at one enables the host interface.
// - Module grant bit 5 at one enables the secure-module interface.
// - Host grant and module grant are never both one.
// - A grant bit may be set only after unlocking; otherwise it is refused.
// - Port select bits 3 to 2: off, SPI, low-speed two-wire, two-wire.
module command_and_bus_access_ctrl #(
   parameter int EXEC_CYCLES = `EXEC_CYCLES
) (
   input  wire logic                                 ref_clk_i,
   input  wire logic                                 rstn_i,
   input  wire logic [6:0]                           reg_addr_i,
   input  wire logic                                 reg_wr_i,
   input  wire logic                                 reg_rd_i,
   input  wire logic [7:0]                           reg_wdata_i,
   output logic      [7:0]                           reg_rdata_o,
   output logic                                      reg_rvalid_o,
   input  wire logic                                 engine_done_i,
   input  wire logic                                 wake_i,
   output logic                                      standby_o,
   output logic                                      radio_frontend_off_o,
   output logic      [4:0]                           cmd_code_o,
   output logic                                      cmd_start_o,
   output logic                                      cmd_busy_o,
   output logic                                      host_bus_grant_o,
   output logic                                      module_bus_grant_o,
   output cmd_access_pkg::module_port_select_type    module_port_select_o,
   output logic                                      module_spi_en_o,
   output logic                                      low_speed_two_wire_en_o,
   output logic                                      two_wire_en_o
);
   import cmd_access_pkg::*;

   // Whole-register reset images; single bits are taken from them below
   localparam logic [7:0] CMD_RESET = `CMD_CONTROL_RESET;
   localparam logic [7:0] ACC_RESET = `ACCESS_CONTROL_RESET;

   // Refuse a run length the sequencer cannot serve
   generate
      if (EXEC_CYCLES < 1) begin : g_bad_exec
         $error("EXEC_CYCLES must be at least one");
      end
   endgenerate

   // Wake pin synchroniser; only the second stage is read by logic
   logic wake_meta;
   logic wake_sync;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end else begin
         wake_meta <= wake_i;
         wake_sync <= wake_meta;
      end
   end

   // Register state
   logic                   access_unlock;
   logic                   seq_busy;
   logic                   seq_finish;
   module_port_select_type port_sel;

   // Address decode of the two registers
   wire logic cmd_hit;
   wire logic acc_hit;
   wire logic cmd_wr;
   wire logic acc_wr;
   wire logic any_wr;

   assign cmd_hit = (reg_addr_i == `CMD_CONTROL_ADDR);
   assign acc_hit = (reg_addr_i == `ACCESS_CONTROL_ADDR);
   assign cmd_wr  = reg_wr_i & cmd_hit;
   assign acc_wr  = reg_wr_i & acc_hit;
   assign any_wr  = reg_wr_i;

   // Write data fields
   wire logic       wr_standby;
   wire logic       wr_modem_off;
   wire logic [4:0] wr_cmd;
   wire logic       wr_unlock;
   wire logic       wr_host;
   wire logic       wr_module;
   wire logic [1:0] wr_port;

   assign wr_standby   = reg_wdata_i[`STANDBY_BIT];
   assign wr_modem_off = reg_wdata_i[`MODEM_OFF_BIT];
   assign wr_cmd       = reg_wdata_i[`CMD_MSB:`CMD_LSB];
   assign wr_unlock    = reg_wdata_i[`UNLOCK_BIT];
   assign wr_host      = reg_wdata_i[`HOST_GRANT_BIT];
   assign wr_module    = reg_wdata_i[`MODULE_GRANT_BIT];
   assign wr_port      = reg_wdata_i[`PORT_SEL_MSB:`PORT_SEL_LSB];

   // Command start and stop requests for the sequencer
   wire logic cmd_start;
   wire logic cmd_stop;

   assign cmd_start = cmd_wr & (wr_cmd != `CMD_IDLE);
   assign cmd_stop  = cmd_wr & (wr_cmd == `CMD_IDLE);

   cmd_sequencer #(
      .EXEC_CYCLES (EXEC_CYCLES)
   ) u_seq (
      .ref_clk_i     (ref_clk_i),
      .rstn_i        (rstn_i),
      .start_i       (cmd_start),
      .stop_i        (cmd_stop),
      .engine_done_i (engine_done_i),
      .busy_o        (seq_busy),
      .finish_o      (seq_finish)
   );

   // Grant arbitration for an access-control write
   wire logic guard_host;
   wire logic guard_module;
   wire logic guard_refused;

   grant_guard u_guard (
      .unlocked_i     (access_unlock),
      .host_grant_i   (host_bus_grant_o),
      .module_grant_i (module_bus_grant_o),
      .req_host_i     (wr_host),
      .req_module_i   (wr_module),
      .next_host_o    (guard_host),
      .next_module_o  (guard_module),
      .refused_o      (guard_refused)
   );

   // Next values of the command register
   wire logic       next_standby;
   wire logic       next_modem_off;
   wire logic [4:0] next_cmd;

   // A standby write in the same cycle as a wake wins, so no request is lost
   assign next_standby   = cmd_wr ? wr_standby : (standby_o & ~wake_sync);
   assign next_modem_off = cmd_wr ? wr_modem_off : radio_frontend_off_o;
   // A host write in the finishing cycle starts a new command and must not be wiped
   assign next_cmd       = cmd_wr ? wr_cmd :
                           (seq_finish ? `CMD_IDLE : cmd_code_o);

   // Next values of the access-control register
   wire logic                   next_unlock;
   wire logic                   next_host;
   wire logic                   next_module;
   module_port_select_type      next_port;

   // Any write consumes the unlock; a locked write to bit 7 arms it
   assign next_unlock = any_wr ? (acc_wr & wr_unlock & ~access_unlock) : access_unlock;
   assign next_host   = acc_wr ? guard_host : host_bus_grant_o;
   assign next_module = acc_wr ? guard_module : module_bus_grant_o;
   assign next_port   = acc_wr ? module_port_select_type'(wr_port) : port_sel;

   // Read data; reserved bits read as zero, unmapped addresses read zero
   wire logic [7:0] cmd_view;
   wire logic [7:0] acc_view;
   wire logic [7:0] next_rdata;

   assign cmd_view   = {standby_o, radio_frontend_off_o, 1'b0, cmd_code_o};
   assign acc_view   = {access_unlock, host_bus_grant_o, module_bus_grant_o, 1'b0,
                        port_sel, 2'h0};
   assign next_rdata = cmd_hit ? cmd_view : (acc_hit ? acc_view : `READ_ZERO);

   // Command register and its driven outputs
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         standby_o            <= CMD_RESET[`STANDBY_BIT];
         radio_frontend_off_o <= CMD_RESET[`MODEM_OFF_BIT];
         cmd_code_o           <= `CMD_IDLE;
         cmd_start_o          <= 1'b0;
         cmd_busy_o           <= 1'b0;
      end else begin
         standby_o            <= next_standby;
         radio_frontend_off_o <= next_modem_off;
         cmd_code_o           <= next_cmd;
         cmd_start_o          <= cmd_start;
         cmd_busy_o           <= seq_busy;
      end
   end

   // Access-control register and the decoded port enables
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         access_unlock           <= ACC_RESET[`UNLOCK_BIT];
         host_bus_grant_o        <= ACC_RESET[`HOST_GRANT_BIT];
         module_bus_grant_o      <= ACC_RESET[`MODULE_GRANT_BIT];
         port_sel                <= PORT_OFF;
         module_port_select_o    <= PORT_OFF;
         module_spi_en_o         <= 1'b0;
         low_speed_two_wire_en_o <= 1'b0;
         two_wire_en_o           <= 1'b0;
      end else begin
         access_unlock           <= next_unlock;
         host_bus_grant_o        <= next_host;
         module_bus_grant_o      <= next_module;
         port_sel                <= next_port;
         module_port_select_o    <= next_port;
         module_spi_en_o         <= (next_port == PORT_SPI);
         low_speed_two_wire_en_o <= (next_port == PORT_LOW_SPEED_TWO_WIRE);
         two_wire_en_o           <= (next_port == PORT_TWO_WIRE);
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o  <= `READ_ZERO;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o  <= reg_rd_i ? next_rdata : `READ_ZERO;
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // Checks on the register behaviour
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence seq_unlock_write;
      acc_wr && wr_unlock && !access_unlock;
   endsequence

   // Any write while unlocked, whatever its address
   sequence seq_unlock_consume;
      access_unlock && reg_wr_i;
   endsequence

   // Claims made while unlocked; writes may be spaced, the unlock waits for them
   sequence seq_host_claim;
      acc_wr && access_unlock && wr_host && !wr_module;
   endsequence

   sequence seq_module_claim;
      acc_wr && access_unlock && wr_module && !wr_host;
   endsequence

   AST_STANDBY_WRITE: assert property (
      cmd_wr |=> standby_o == $past(wr_standby))
      else $error("standby does not follow the command write");

   AST_WAKE_CLEARS: assert property (
      (standby_o && wake_sync && !reg_wr_i) |=> !standby_o)
      else $error("wake did not leave standby");

   AST_MODEM_OFF: assert property (
      cmd_wr |=> radio_frontend_off_o == $past(wr_modem_off) ##1
                 (radio_frontend_off_o == $past(radio_frontend_off_o) || $past(cmd_wr)))
      else $error("radio front end power state wrong");

   AST_CMD_CODE: assert property (
      cmd_start |=> cmd_code_o == $past(wr_cmd) ##1 cmd_busy_o)
      else $error("command code or busy wrong after start");

   AST_CMD_IDLE: assert property (
      (seq_finish && !cmd_wr) |=> cmd_code_o == `CMD_IDLE)
      else $error("command field did not return to idle");

   AST_UNLOCK_ONCE: assert property (
      seq_unlock_consume |=> !access_unlock)
      else $error("unlock lasted past one write");

   AST_UNLOCKED_HOST: assert property (
      seq_host_claim |=> host_bus_grant_o && !module_bus_grant_o)
      else $error("unlocked host claim not granted");

   AST_UNLOCKED_MODULE: assert property (
      seq_module_claim |=> module_bus_grant_o && !host_bus_grant_o)
      else $error("unlocked module claim not granted");

   AST_EXCLUSIVE: assert property (
      !(host_bus_grant_o && module_bus_grant_o))
      else $error("both grants active");

   AST_LOCKED_REFUSED: assert property (
      (acc_wr && !access_unlock) |=> !$rose(host_bus_grant_o) && !$rose(module_bus_grant_o))
      else $error("grant set without unlock");

   AST_BOTH_REFUSED: assert property (
      (acc_wr && wr_host && wr_module) |=>
         $stable(host_bus_grant_o) && $stable(module_bus_grant_o))
      else $error("double grant write changed the grants");

   AST_PORT_DECODE: assert property (
      acc_wr |=> module_port_select_o == $past(wr_port) &&
                 module_spi_en_o == (module_port_select_o == PORT_SPI) &&
                 low_speed_two_wire_en_o ==
                    (module_port_select_o == PORT_LOW_SPEED_TWO_WIRE) &&
                 two_wire_en_o == (module_port_select_o == PORT_TWO_WIRE))
      else $error("module port select decode wrong");

   AST_UNLOCK_ARMS: assert property (
      seq_unlock_write |=> access_unlock)
      else $error("unlock write did not arm the unlock");

   AST_CMD_HOLD: assert property (
      (!cmd_wr && !seq_finish) |=> $stable(cmd_code_o))
      else $error("command code changed with no write and no finish");

   AST_STANDBY_HOLD: assert property (
      (!cmd_wr && !wake_sync) |=> $stable(standby_o))
      else $error("standby changed with no write and no wake");

endmodule

/* testbench/host_model.sv */
// Host microcontroller model that drives single register writes and reads
`include "cmd_access_regs.svh"
module host_model (
   input  wire logic       ref_clk_i,
   output logic      [6:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines show a value unlike any real request
   initial begin
      reg_addr_o  = 7'h7F;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 8'hFF;
   end

   // One write; reserved positions always go out as zero
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] mask;
      mask = (a == `ACCESS_CONTROL_ADDR) ? 8'hEC : 8'hDF;
      @(posedge ref_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d & mask;
      reg_wr_o    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a; // Released lines invert rather than hold
      reg_wdata_o <= ~(d & mask);
   endtask

   // One read; the answer is taken in the cycle after the strobe
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      @(negedge ref_clk_i);
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask

   // Setting a grant needs the unlock write first
   task automatic unlock_write(input logic [7:0] d);
      write_reg(`ACCESS_CONTROL_ADDR, 8'h80);
      write_reg(`ACCESS_CONTROL_ADDR, d);
   endtask
endmodule

/* testbench/command_and_bus_access_ctrl_test.sv */
// Self-checking bench for the command and access-control registers
`include "cmd_access_regs.svh"
module command_and_bus_access_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cmd_access_pkg::*;

   localparam int EXEC = 4; // Short run time keeps the auto-end test brief

   logic                   ref_clk = 1'b0;
   logic                   rstn = 1'b0;
   logic [6:0]             reg_addr;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [7:0]             reg_wdata;
   logic [7:0]             reg_rdata;
   logic                   reg_rvalid;
   logic                   engine_done = 1'b0;
   logic                   wake = 1'b0;
   logic                   standby;
   logic                   radio_off;
   logic [4:0]             cmd_code;
   logic                   cmd_start;
   logic                   cmd_busy;
   logic                   host_grant;
   logic                   module_grant;
   module_port_select_type port_sel;
   logic                   spi_en;
   logic                   ls_en;
   logic                   tw_en;
   int                     fails = 0;
   int                     checks = 0;
   int                     cycles = 0;
   logic [7:0]             rd_data;
   logic                   rd_ok;
   int                     run_len;

   always #4 ref_clk = ~ref_clk;

   command_and_bus_access_ctrl #(.EXEC_CYCLES(EXEC)) dut_u (
      .ref_clk_i               (ref_clk),
      .rstn_i                  (rstn),
      .reg_addr_i              (reg_addr),
      .reg_wr_i                (reg_wr),
      .reg_rd_i                (reg_rd),
      .reg_wdata_i             (reg_wdata),
      .reg_rdata_o             (reg_rdata),
      .reg_rvalid_o            (reg_rvalid),
      .engine_done_i           (engine_done),
      .wake_i                  (wake),
      .standby_o               (standby),
      .radio_frontend_off_o    (radio_off),
      .cmd_code_o              (cmd_code),
      .cmd_start_o             (cmd_start),
      .cmd_busy_o              (cmd_busy),
      .host_bus_grant_o        (host_grant),
      .module_bus_grant_o      (module_grant),
      .module_port_select_o    (port_sel),
      .module_spi_en_o         (spi_en),
      .low_speed_two_wire_en_o (ls_en),
      .two_wire_en_o           (tw_en)
   );

   host_model host_u (
      .ref_clk_i    (ref_clk),
      .reg_addr_o   (reg_addr),
      .reg_wr_o     (reg_wr),
      .reg_rd_o     (reg_rd),
      .reg_wdata_o  (reg_wdata),
      .reg_rdata_i  (reg_rdata),
      .reg_rvalid_i (reg_rvalid)
   );

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Read one register and compare answer strobe and data
   task automatic read_check(input logic [6:0] a, input logic [7:0] exp);
      host_u.read_reg(a, rd_data, rd_ok);
      check("read valid", {7'h00, rd_ok}, 8'h01);
      check("read data", rd_data, exp);
   endtask

   // Grants, select field and its one-hot decode in one compare
   task automatic access_check(input logic h, input logic m, input logic [1:0] s);
      logic [7:0] exp;
      exp = {h, m, 1'b0, s == 2'h1, s == 2'h2, s == 2'h3, s};
      @(negedge ref_clk);
      check("grants", {host_grant, module_grant, 1'b0, spi_en, ls_en, tw_en, port_sel}, exp);
   endtask

   // Bounded wait for the running command to return to idle
   task automatic wait_idle(input int limit, output int n);
      n = 0;
      while ((cmd_code !== `CMD_IDLE || cmd_busy !== 1'b0) && n < limit) begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   // A hang is cut short here and counted as a mismatch
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      // Reset values and an unmapped read
      access_check(1'b1, 1'b0, 2'h0);
      read_check(`CMD_CONTROL_ADDR, `CMD_CONTROL_RESET);
      read_check(`ACCESS_CONTROL_ADDR, `ACCESS_CONTROL_RESET);
      read_check(7'h10, `READ_ZERO);
      $display("test reset done");
      // Grant claim while locked is refused, select still taken
      host_u.write_reg(`ACCESS_CONTROL_ADDR, 8'h24);
      access_check(1'b1, 1'b0, 2'h1);
      // Unlock is visible and the next write consumes it
      host_u.write_reg(`ACCESS_CONTROL_ADDR, 8'h80);
      read_check(`ACCESS_CONTROL_ADDR, 8'h80);
      host_u.write_reg(`ACCESS_CONTROL_ADDR, 8'h24);
      access_check(1'b0, 1'b1, 2'h1);
      read_check(`ACCESS_CONTROL_ADDR, 8'h24);
      // Both grants at once are refused even when unlocked
      // The unlock write repeats the module grant so that it is kept
      host_u.write_reg(`ACCESS_CONTROL_ADDR, 8'hA4);
      host_u.write_reg(`ACCESS_CONTROL_ADDR, 8'h60);
      access_check(1'b0, 1'b1, 2'h0);
      read_check(`ACCESS_CONTROL_ADDR, 8'h20);
      $display("test grants done");
      // Host grant with every select code
      for (int s = 0; s < 4; s++) begin
         host_u.unlock_write({4'h4, s[1:0], 2'h0});
         access_check(1'b1, 1'b0, s[1:0]);
      end
      $display("test select done");
      // Command ends by itself after the run time
      host_u.write_reg(`CMD_CONTROL_ADDR, 8'h05);
      @(negedge ref_clk);
      check("code", {3'h0, cmd_code}, 8'h05);
      check("start", {7'h00, cmd_start}, 8'h01);
      @(negedge ref_clk);
      check("busy", {7'h00, cmd_busy}, 8'h01);
      check("start pulse", {7'h00, cmd_start}, 8'h00);
      wait_idle(EXEC + 8, run_len);
      check("run length", run_len[7:0], 8'(EXEC));
      check("auto idle", {3'h0, cmd_code, cmd_busy, 2'h0}, 8'h00);
      // Command ended early by the engine report
      host_u.write_reg(`CMD_CONTROL_ADDR, 8'h1F);
      @(posedge ref_clk);
      engine_done <= 1'b1;
      @(posedge ref_clk);
      engine_done <= 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("done idle", {3'h0, cmd_code}, 8'h00);
      read_check(`CMD_CONTROL_ADDR, 8'h00);
      $display("test command done");
      // Standby and radio power-down, then wake
      host_u.write_reg(`CMD_CONTROL_ADDR, 8'hC0);
      @(negedge ref_clk);
      check("standby", {6'h00, standby, radio_off}, 8'h03);
      read_check(`CMD_CONTROL_ADDR, 8'hC0);
      @(posedge ref_clk);
      wake <= 1'b1;
      repeat (10) @(posedge ref_clk);
      wake <= 1'b0;
      @(negedge ref_clk);
      check("woken", {6'h00, standby, radio_off}, 8'h01);
      host_u.write_reg(`CMD_CONTROL_ADDR, 8'h00);
      @(negedge ref_clk);
      check("radio on", {6'h00, standby, radio_off}, 8'h00);
      // An unmapped write while locked leaves both registers alone
      host_u.write_reg(7'h10, 8'hFF);
      read_check(`CMD_CONTROL_ADDR, 8'h00);
      read_check(`ACCESS_CONTROL_ADDR, 8'h4C);
      $display("test power done");
      tally_and_finish();
   end
endmodule
